// ---- hw/alm_pkg.sv ----
// Shared constants, register map and types of the adaptive linefeed monitor
package alm_pkg;
  // ----------------------------------------------------------------
  // Clock and sample rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 125_000_000;
  localparam int SLOW_RATE_HZ  = 800;
  localparam int FAST_RATE_HZ  = 8000;
  localparam int SLOW_DIV      = CLK_HZ / SLOW_RATE_HZ;
  localparam int FAST_DIV      = CLK_HZ / FAST_RATE_HZ;
  localparam int CAL_CYCLES    = 512;
  localparam int CNT_W         = 18;
  localparam int CAL_W         = 16;
  // ----------------------------------------------------------------
  // Linefeed state codes
  // ----------------------------------------------------------------
  localparam logic [2:0] LF_OPEN      = 3'h0;
  localparam logic [2:0] LF_FWD       = 3'h1;
  localparam logic [2:0] LF_TIP_LEAD_OPEN_STATE  = 3'h3;
  localparam logic [2:0] LF_REV       = 3'h5;
  localparam logic [2:0] LF_REV_OHT   = 3'h6;
  localparam logic [2:0] LF_RING_OPEN = 3'h7;
  // ----------------------------------------------------------------
  // Register word addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] A_CTRL   = 5'h00;
  localparam logic [4:0] A_STATUS = 5'h01;
  localparam logic [4:0] A_VOC    = 5'h02;
  localparam logic [4:0] A_VOV    = 5'h03;
  localparam logic [4:0] A_VCM    = 5'h04;
  localparam logic [4:0] A_BOOST  = 5'h05;
  localparam logic [4:0] A_DROP   = 5'h06;
  localparam logic [4:0] A_RISE   = 5'h07;
  localparam logic [4:0] A_TRACK  = 5'h08;
  localparam logic [4:0] A_CURRENT_LIMIT   = 5'h09;
  localparam logic [4:0] A_GKLO   = 5'h0A;
  localparam logic [4:0] A_GKHI   = 5'h0B;
  localparam logic [4:0] A_GKLPF  = 5'h0C;
  localparam logic [4:0] A_GKDB   = 5'h0D;
  localparam logic [4:0] A_TARGET = 5'h0E;
  localparam logic [4:0] A_LOOP_VOLTAGE_SENSE  = 5'h10;
  localparam logic [4:0] A_TIP_VOLTAGE_SENSE   = 5'h11;
  localparam logic [4:0] A_RING_VOLTAGE_SENSE  = 5'h12;
  localparam logic [4:0] A_LOOP_CURRENT_SENSE  = 5'h13;
  localparam logic [4:0] A_VBAT   = 5'h14;
  localparam logic [4:0] A_LONGITUDINAL_CURRENT_SENSE  = 5'h15;
  localparam logic [4:0] A_RGV    = 5'h16;
  localparam logic [4:0] A_RGI    = 5'h17;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_CAL      = 3;
  localparam int B_DISCRETE = 4;
  localparam int B_GKFLAG   = 0;
  localparam int B_PWRFLAG  = 1;
  localparam int B_LOWIMP   = 2;
  localparam int B_CURLIM   = 3;
  localparam int B_CALBUSY  = 4;
  localparam int LPF_SHIFT  = 8;
  localparam logic [7:0] SCALE_PAD = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tip_v;
    logic [7:0] ring_v;
    logic [7:0] bat_v;
    logic [7:0] tip_i;
    logic [7:0] ring_i;
    logic [7:0] rgen_v;
    logic [7:0] rgen_i;
  } alm_sense_t;
  localparam int SYNC_W = $bits(alm_sense_t) + 1;
  typedef struct packed {
    logic [SYNC_W-1:0] sy1, sy2, sy3, held;
    logic [CNT_W-1:0]  slow_cnt, fast_cnt;
    logic [CAL_W-1:0]  cal_cnt;
    logic [2:0]        lf;
    logic              cal, discrete, gk_flag, pwr_flag, pwr_prev;
    logic              low_imp, cur_lim, gk_armed;
    logic [15:0]       programmed_open_voltage, overhead_voltage, common_mode_voltage, boost, drop, rise, current_limit, gklo, gkhi;
    logic [7:0]        gkc, gkd, gk_cnt;
    logic [15:0]       tracked, target, gk_filt;
    logic [15:0]       loop_voltage_sense, tip_voltage_sense, ring_voltage_sense, loop_current_sense, vbat, longitudinal_current_sense, rgv, rgi;
    logic [15:0]       rdata;
    logic              tip_hiz, ring_hiz, imp_640, reverse;
  } alm_state_t;
endpackage

// ---- hw/alm_top.sv ----
// Adaptive linefeed control, ground start, calibration and loop monitor
// What this block does
// - Current limit flagged only in 320 ohm feed
// - Rise threshold: 640 ohm, drop boost
// - Ample battery: tracked equals programmed open voltage
// - Low battery: tracked is battery minus overheads
// - Thresholds are offsets from tracked voltage
// - Codes 011 and 111 select ground start
// - Named lead high impedance, other driven
// - Ground start uses same impedances, thresholds
// - Ground key: filtered longitudinal current, thresholds
// - Debounced ground key sets status flag
// - Ground key moves state to active
// - Calibrate bit self clears when done
// - Reset gives open state, calibration allowed
// - Eight bit samples readable in registers
// - Monitors at 800 Hz, ringer 8 kHz
// - Report loop voltage and loop current
// - Ground start reports ring lead values
// - Currents derived from transistor currents
// - Ringer voltage and current result scaling
// - Excess power forces open, raises alarm
// - Drop threshold: 320 ohm, add boost
// - Zero boost keeps impedance change only
// - Reverse active encoded as 101
`timescale 1ns/100ps
module alm_top import alm_pkg::*; #(
  parameter int SLOW_DIV_P   = SLOW_DIV,
  parameter int FAST_DIV_P   = FAST_DIV,
  parameter int CAL_CYCLES_P = CAL_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Register port
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Converter samples and power monitor
  input  wire alm_sense_t  sense_i,
  input  wire logic        power_excess_i,
  // Linefeed stage control
  output logic             tip_hiz_o,
  output logic             ring_hiz_o,
  output logic             imp_640_o,
  output logic             reverse_o,
  output logic      [15:0] feed_target_o,
  output logic             cal_run_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_DIV_P - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_DIV_P - 1);
  localparam logic [CAL_W-1:0] CAL_LAST  = CAL_W'(CAL_CYCLES_P - 1);
  alm_state_t st_ff, nxt_st;
  logic slow_t, fast_t, gk_ev, pwr_rise, active;
  logic [SYNC_W-1:0] agree;
  alm_sense_t s;
  logic [15:0] it16, ir16, longitudinal_current_sense_abs;
  logic signed [17:0] vd, vmag, lo_th, hi_th;
  logic signed [16:0] ld, la, diff;
  logic signed [25:0] prod;
  logic signed [17:0] newf;
  logic [17:0] vsum;
  logic [16:0] ovcm, tsum;
  logic [15:0] rsel;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    slow_t    = (st_ff.slow_cnt == SLOW_LAST);
    fast_t    = (st_ff.fast_cnt == FAST_LAST);
    agree     = ~(st_ff.sy2 ^ st_ff.sy3);
    s         = alm_sense_t'(st_ff.held[SYNC_W-2:0]);
    pwr_rise  = st_ff.held[SYNC_W-1] & ~st_ff.pwr_prev;
    gk_ev     = 1'b0;
    active    = (st_ff.lf != LF_OPEN);
    it16      = {s.tip_i, SCALE_PAD};
    ir16      = {s.ring_i, SCALE_PAD};
    vd        = 18'sd0;
    vmag      = 18'sd0;
    lo_th     = 18'sd0;
    hi_th     = 18'sd0;
    ld        = $signed({1'b0, it16}) - $signed({1'b0, ir16});
    la        = ld[16] ? -ld : ld;
    longitudinal_current_sense_abs = la[16:1];
    diff      = $signed({1'b0, longitudinal_current_sense_abs}) - $signed({1'b0, st_ff.gk_filt});
    prod      = diff * $signed({1'b0, st_ff.gkc});
    newf      = $signed({2'b00, st_ff.gk_filt}) + 18'(prod >>> LPF_SHIFT);
    vsum      = {2'b00, st_ff.programmed_open_voltage} + {2'b00, st_ff.overhead_voltage} + {2'b00, st_ff.common_mode_voltage};
    ovcm      = {1'b0, st_ff.overhead_voltage} + {1'b0, st_ff.common_mode_voltage};
    tsum      = {1'b0, st_ff.tracked} + {1'b0, st_ff.boost};
    rsel      = 16'h0000;
    // Three stage input capture, a change is taken once the last two stages agree
    nxt_st.sy1      = {power_excess_i, sense_i};
    nxt_st.sy2      = st_ff.sy1;
    nxt_st.sy3      = st_ff.sy2;
    nxt_st.held     = (st_ff.held & ~agree) | (st_ff.sy3 & agree);
    nxt_st.pwr_prev = st_ff.held[SYNC_W-1];
    // Sample rate dividers
    nxt_st.slow_cnt = slow_t ? '0 : CNT_W'(st_ff.slow_cnt + 1'b1);
    nxt_st.fast_cnt = fast_t ? '0 : CNT_W'(st_ff.fast_cnt + 1'b1);
    // Open voltage tracking against battery
    if ({2'b00, st_ff.vbat} >= vsum) begin
      nxt_st.tracked = st_ff.programmed_open_voltage;
    end else if ({1'b0, st_ff.vbat} > ovcm) begin
      nxt_st.tracked = 16'(st_ff.vbat - ovcm[15:0]);
    end else begin
      nxt_st.tracked = 16'h0000;
    end
    // Ringer inputs at the fast rate
    if (fast_t) begin
      nxt_st.rgv = {s.rgen_v, SCALE_PAD};
      nxt_st.rgi = {s.rgen_i, SCALE_PAD};
    end
    // Monitor samples at the slow rate
    if (slow_t) begin
      nxt_st.tip_voltage_sense  = {s.tip_v, SCALE_PAD};
      nxt_st.ring_voltage_sense = {s.ring_v, SCALE_PAD};
      nxt_st.vbat  = {s.bat_v, SCALE_PAD};
      nxt_st.longitudinal_current_sense = ld[16:1];
      if (st_ff.lf == LF_TIP_LEAD_OPEN_STATE || st_ff.lf == LF_RING_OPEN) begin
        vd           = $signed({2'b00, s.ring_v, SCALE_PAD});
        nxt_st.loop_current_sense = ir16;
      end else begin
        vd           = $signed({2'b00, s.tip_v, SCALE_PAD})
                     - $signed({2'b00, s.ring_v, SCALE_PAD});
        nxt_st.loop_current_sense = 16'(({1'b0, it16} + {1'b0, ir16}) >> 1);
      end
      nxt_st.loop_voltage_sense = vd[15:0];
      vmag  = vd[17] ? -vd : vd;
      lo_th = $signed({2'b00, st_ff.tracked}) + 18'($signed(st_ff.drop));
      hi_th = $signed({2'b00, st_ff.tracked}) + 18'($signed(st_ff.rise));
      // Adaptive feed hysteresis, same in loop and ground start
      if (!active) begin
        nxt_st.low_imp = 1'b0;
      end else if (!st_ff.low_imp && vmag <= lo_th) begin
        nxt_st.low_imp = 1'b1;
      end else if (st_ff.low_imp && vmag >= hi_th) begin
        nxt_st.low_imp = 1'b0;
      end
      nxt_st.cur_lim = nxt_st.low_imp && (nxt_st.loop_current_sense >= st_ff.current_limit);
      // Ground key filter and debounce
      nxt_st.gk_filt = newf[15:0];
      if (st_ff.gk_filt > st_ff.gkhi) begin
        if (st_ff.gk_cnt < st_ff.gkd) begin
          nxt_st.gk_cnt = 8'(st_ff.gk_cnt + 1'b1);
        end else if (!st_ff.gk_armed) begin
          gk_ev           = 1'b1;
          nxt_st.gk_armed = 1'b1;
        end
      end else if (st_ff.gk_filt < st_ff.gklo) begin
        nxt_st.gk_cnt   = 8'h00;
        nxt_st.gk_armed = 1'b0;
      end
    end
    // Feed target follows the impedance region
    if (st_ff.low_imp) begin
      nxt_st.target = tsum[16] ? 16'hFFFF : tsum[15:0];
    end else begin
      nxt_st.target = st_ff.tracked;
    end
    // Calibration cycle
    if (st_ff.cal) begin
      if (st_ff.cal_cnt == '0) begin
        nxt_st.cal = 1'b0;
      end else begin
        nxt_st.cal_cnt = CAL_W'(st_ff.cal_cnt - 1'b1);
      end
    end
    // Register writes
    if (wr_i) begin
      case (addr_i)
        A_CTRL: begin
          nxt_st.lf       = wdata_i[2:0];
          nxt_st.discrete = wdata_i[B_DISCRETE];
          if (wdata_i[B_CAL] && !st_ff.cal) begin
            nxt_st.cal     = 1'b1;
            nxt_st.cal_cnt = CAL_LAST;
          end
        end
        A_STATUS: begin
          if (wdata_i[B_GKFLAG]) nxt_st.gk_flag = 1'b0;
          if (wdata_i[B_PWRFLAG]) nxt_st.pwr_flag = 1'b0;
        end
        A_VOC:   nxt_st.programmed_open_voltage   = wdata_i;
        A_VOV:   nxt_st.overhead_voltage   = wdata_i;
        A_VCM:   nxt_st.common_mode_voltage   = wdata_i;
        A_BOOST: nxt_st.boost = wdata_i;
        A_DROP:  nxt_st.drop  = wdata_i;
        A_RISE:  nxt_st.rise  = wdata_i;
        A_CURRENT_LIMIT:  nxt_st.current_limit  = wdata_i;
        A_GKLO:  nxt_st.gklo  = wdata_i;
        A_GKHI:  nxt_st.gkhi  = wdata_i;
        A_GKLPF: nxt_st.gkc   = wdata_i[7:0];
        A_GKDB:  nxt_st.gkd   = wdata_i[7:0];
        default: ;
      endcase
    end
    // Hardware events win over a software write in the same cycle
    if (gk_ev) begin
      nxt_st.gk_flag = 1'b1;
      if (st_ff.lf == LF_TIP_LEAD_OPEN_STATE) nxt_st.lf = LF_FWD;
      if (st_ff.lf == LF_RING_OPEN) nxt_st.lf = LF_REV;
    end
    if (pwr_rise) begin
      nxt_st.pwr_flag = 1'b1;
      nxt_st.lf       = LF_OPEN;
    end
    // Lead drive and impedance outputs
    nxt_st.tip_hiz  = (nxt_st.lf == LF_OPEN) || (nxt_st.lf == LF_TIP_LEAD_OPEN_STATE);
    nxt_st.ring_hiz = (nxt_st.lf == LF_OPEN) || (nxt_st.lf == LF_RING_OPEN);
    nxt_st.reverse  = (nxt_st.lf == LF_REV) || (nxt_st.lf == LF_REV_OHT);
    nxt_st.imp_640  = !nxt_st.low_imp && !nxt_st.discrete;
    // Register reads, data in the following cycle only
    case (addr_i)
      A_CTRL:   rsel = {11'h000, st_ff.discrete, st_ff.cal, st_ff.lf};
      A_STATUS: rsel = {11'h000, st_ff.cal, st_ff.cur_lim, st_ff.low_imp,
                        st_ff.pwr_flag, st_ff.gk_flag};
      A_VOC:    rsel = st_ff.programmed_open_voltage;
      A_VOV:    rsel = st_ff.overhead_voltage;
      A_VCM:    rsel = st_ff.common_mode_voltage;
      A_BOOST:  rsel = st_ff.boost;
      A_DROP:   rsel = st_ff.drop;
      A_RISE:   rsel = st_ff.rise;
      A_TRACK:  rsel = st_ff.tracked;
      A_CURRENT_LIMIT:   rsel = st_ff.current_limit;
      A_GKLO:   rsel = st_ff.gklo;
      A_GKHI:   rsel = st_ff.gkhi;
      A_GKLPF:  rsel = {8'h00, st_ff.gkc};
      A_GKDB:   rsel = {8'h00, st_ff.gkd};
      A_TARGET: rsel = st_ff.target;
      A_LOOP_VOLTAGE_SENSE:  rsel = st_ff.loop_voltage_sense;
      A_TIP_VOLTAGE_SENSE:   rsel = st_ff.tip_voltage_sense;
      A_RING_VOLTAGE_SENSE:  rsel = st_ff.ring_voltage_sense;
      A_LOOP_CURRENT_SENSE:  rsel = st_ff.loop_current_sense;
      A_VBAT:   rsel = st_ff.vbat;
      A_LONGITUDINAL_CURRENT_SENSE:  rsel = st_ff.longitudinal_current_sense;
      A_RGV:    rsel = st_ff.rgv;
      A_RGI:    rsel = st_ff.rgi;
      default:  rsel = 16'h0000;
    endcase
    nxt_st.rdata = rd_i ? rsel : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff          <= '0;
      st_ff.lf       <= LF_OPEN;
      st_ff.tip_hiz  <= 1'b1;
      st_ff.ring_hiz <= 1'b1;
      st_ff.imp_640  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o       = st_ff.rdata;
  assign tip_hiz_o     = st_ff.tip_hiz;
  assign ring_hiz_o    = st_ff.ring_hiz;
  assign imp_640_o     = st_ff.imp_640;
  assign reverse_o     = st_ff.reverse;
  assign feed_target_o = st_ff.target;
  assign cal_run_o     = st_ff.cal;

  // ----------------------------------------------------------------
  // Checks on linefeed state, tracking and calibration
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_power_forces_open: assert property (
    pwr_rise |=> st_ff.lf == LF_OPEN && st_ff.pwr_flag)
    else $error("power alarm did not force open");
  a_gk_sets_flag: assert property (
    gk_ev |=> st_ff.gk_flag)
    else $error("ground key flag not set");
  a_gk_tip_fwd: assert property (
    gk_ev && !pwr_rise && st_ff.lf == LF_TIP_LEAD_OPEN_STATE |=> st_ff.lf == LF_FWD)
    else $error("tip_lead_open_state did not go forward active");
  a_gk_ring_rev: assert property (
    gk_ev && !pwr_rise && st_ff.lf == LF_RING_OPEN |=> st_ff.lf == LF_REV)
    else $error("ring open did not go reverse active");
  a_gk_debounced: assert property (
    gk_ev |-> slow_t && st_ff.gk_filt > st_ff.gkhi && st_ff.gk_cnt >= st_ff.gkd)
    else $error("ground key event before debounce");
  a_track_full_bat: assert property (
    {2'b00, st_ff.vbat} >= vsum |=> st_ff.tracked == $past(st_ff.programmed_open_voltage))
    else $error("tracked voltage differs from programmed");
  a_track_low_bat: assert property (
    {2'b00, st_ff.vbat} < vsum && {1'b0, st_ff.vbat} > ovcm
    |=> st_ff.tracked == 16'($past(st_ff.vbat) - $past(ovcm[15:0])))
    else $error("tracked voltage not battery minus overhead");
  a_drop_low_imp: assert property (
    slow_t && active && !st_ff.low_imp && vmag <= lo_th
    |=> st_ff.low_imp ##1 !st_ff.imp_640)
    else $error("drop threshold did not lower impedance");
  a_rise_high_imp: assert property (
    slow_t && active && st_ff.low_imp && vmag >= hi_th
    |=> !st_ff.low_imp ##1 st_ff.target == $past(st_ff.tracked))
    else $error("rise threshold did not restore impedance");
  a_lead_open: assert property (
    st_ff.lf == LF_TIP_LEAD_OPEN_STATE |-> st_ff.tip_hiz && !st_ff.ring_hiz)
    else $error("tip_lead_open_state lead drive wrong");
  a_ring_lead_open: assert property (
    st_ff.lf == LF_RING_OPEN |-> st_ff.ring_hiz && !st_ff.tip_hiz)
    else $error("ring open lead drive wrong");
  a_open_high_imp: assert property (
    slow_t && !active |=> !st_ff.low_imp)
    else $error("open state kept low impedance");
  a_boost_target: assert property (
    st_ff.low_imp && !tsum[16] |=> st_ff.target == $past(tsum[15:0]))
    else $error("feed target lacks the boost");
  a_cal_starts: assert property (
    wr_i && addr_i == A_CTRL && wdata_i[B_CAL] && !st_ff.cal |=> st_ff.cal)
    else $error("calibrate request not taken");
  a_cal_clears: assert property (
    $rose(st_ff.cal) |-> st_ff.cal [*1] ##[1:600] !st_ff.cal)
    else $error("calibrate bit did not clear");

  // ----------------------------------------------------------------
  // Checks on monitor samples and reads
  // ----------------------------------------------------------------
  a_gs_loop_voltage: assert property (
    slow_t && (st_ff.lf == LF_TIP_LEAD_OPEN_STATE || st_ff.lf == LF_RING_OPEN)
    |=> st_ff.loop_voltage_sense == {$past(s.ring_v), SCALE_PAD})
    else $error("ground start loop voltage not ring lead");
  a_loop_voltage_diff: assert property (
    slow_t && st_ff.lf != LF_TIP_LEAD_OPEN_STATE && st_ff.lf != LF_RING_OPEN
    |=> st_ff.loop_voltage_sense == 16'({$past(s.tip_v), SCALE_PAD} - {$past(s.ring_v), SCALE_PAD}))
    else $error("loop voltage not tip minus ring");
  a_monitor_rate: assert property (
    !slow_t |=> $stable(st_ff.tip_voltage_sense) && $stable(st_ff.vbat) && $stable(st_ff.loop_voltage_sense))
    else $error("monitor sample changed off its tick");
  a_ringer_rate: assert property (
    !fast_t |=> $stable(st_ff.rgv) && $stable(st_ff.rgi))
    else $error("ringer sample changed off its tick");
  a_ringer_value: assert property (
    fast_t |=> st_ff.rgv == {$past(s.rgen_v), SCALE_PAD}
    && st_ff.rgi == {$past(s.rgen_i), SCALE_PAD})
    else $error("ringer sample not taken on its tick");
  a_read_idle: assert property (
    !rd_i |=> st_ff.rdata == 16'h0000)
    else $error("read data shown without a read");
endmodule // alm_top

// ---- tb/alm_loop_model.sv ----
// Behavioural linefeed stage and subscriber loop facing the block
`timescale 1ns/100ps
module alm_loop_model import alm_pkg::*; (
  // Stage control from the block
  input  wire logic       tip_hiz_i,
  input  wire logic       ring_hiz_i,
  // Loop conditions set by the bench
  input  wire logic [7:0] bat_v_i,
  input  wire logic       closed_i,
  input  wire logic       gnd_key_i,
  input  wire logic       pwr_i,
  // Sensed values back to the block
  output alm_sense_t      sense_o,
  output logic            power_excess_o
);
  always_comb begin
    sense_o        = '0;
    sense_o.bat_v  = bat_v_i;
    sense_o.rgen_v = 8'h5A;
    sense_o.rgen_i = 8'hA5;
    // An open lead carries no voltage and no current
    if (!tip_hiz_i) begin
      sense_o.tip_v = closed_i ? 8'h28 : 8'h3C;
      sense_o.tip_i = closed_i ? 8'h10 : 8'h00;
    end
    if (!ring_hiz_i) begin
      sense_o.ring_v = 8'h08;
      sense_o.ring_i = closed_i ? 8'h10 : 8'h00;
    end
    // Ground key draws current only in the driven lead
    if (gnd_key_i && tip_hiz_i && !ring_hiz_i) sense_o.ring_i = 8'h40;
    if (gnd_key_i && ring_hiz_i && !tip_hiz_i) sense_o.tip_i = 8'h40;
    power_excess_o = pwr_i;
  end
endmodule // alm_loop_model

// ---- tb/test_adaptive_linefeed_monitor.sv ----
// Self-checking bench of the adaptive linefeed monitor
`timescale 1ns/100ps
module test_adaptive_linefeed_monitor import alm_pkg::*;;
  localparam int CALN = 20;
  logic clk, arst_n, wr, rd, pwr_ex, tip_hiz, ring_hiz, imp_640, reverse, cal_run;
  logic closed, gnd_key, pwr;
  logic [4:0] addr;
  logic [7:0] bat_v;
  logic [15:0] wdata, rdata, target, d;
  alm_sense_t sense;
  int err_count, n_compared;
  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  alm_top #(.SLOW_DIV_P(64), .FAST_DIV_P(16), .CAL_CYCLES_P(CALN)) dut (
    .clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .sense_i(sense), .power_excess_i(pwr_ex),
    .tip_hiz_o(tip_hiz), .ring_hiz_o(ring_hiz), .imp_640_o(imp_640),
    .reverse_o(reverse), .feed_target_o(target), .cal_run_o(cal_run));
  alm_loop_model far (
    .tip_hiz_i(tip_hiz), .ring_hiz_i(ring_hiz), .bat_v_i(bat_v), .closed_i(closed),
    .gnd_key_i(gnd_key), .pwr_i(pwr), .sense_o(sense), .power_excess_o(pwr_ex));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic settle();
    repeat (140) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_active();
    int n;
    n = 0;
    while ((tip_hiz | ring_hiz) !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1 chk({15'h0, n < 3000}, 16'h0001, "ground key");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    #1 chk({11'h0, tip_hiz, ring_hiz, imp_640, reverse, cal_run}, 16'h001C, "rst");
    rd_reg(A_CTRL, d);
    chk(d, 16'h0000, "rst ctrl");
  endtask
  task automatic t_cal();
    wr_reg(A_CTRL, 16'h0008);
    repeat (10) @(posedge clk);
    #1 chk({15'h0, cal_run}, 16'h0001, "cal run");
    repeat (CALN) @(posedge clk);
    #1 chk({15'h0, cal_run}, 16'h0000, "cal end");
    rd_reg(A_CTRL, d);
    chk(d, 16'h0000, "cal bit");
  endtask
  task automatic t_track();
    wr_reg(A_VOC, 16'h3000);
    wr_reg(A_VOV, 16'h0400);
    wr_reg(A_VCM, 16'h0300);
    settle();
    rd_reg(A_TRACK, d);
    chk(d, 16'h3000, "track ample");
    bat_v <= 8'h30;
    settle();
    rd_reg(A_TRACK, d);
    chk(d, 16'h2900, "track low");
    wr_reg(A_TRACK, 16'hFFFF);
    rd_reg(A_TRACK, d);
    chk(d, 16'h2900, "track ro");
    rd_reg(5'h1F, d);
    chk(d, 16'h0000, "unmapped");
    bat_v <= 8'h40;
  endtask
  task automatic t_sense();
    logic [4:0] sa [8];
    logic [15:0] se [8];
    sa = '{A_LOOP_VOLTAGE_SENSE, A_TIP_VOLTAGE_SENSE, A_RING_VOLTAGE_SENSE, A_LOOP_CURRENT_SENSE, A_VBAT, A_LONGITUDINAL_CURRENT_SENSE, A_RGV, A_RGI};
    se = '{16'h2000, 16'h2800, 16'h0800, 16'h1000, 16'h4000, 16'h0000, 16'h5A00, 16'hA500};
    wr_reg(A_CTRL, 16'h0001);
    closed <= 1'b1;
    settle();
    for (int i = 0; i < 8; i++) begin
      rd_reg(sa[i], d);
      chk(d, se[i], "sense");
    end
  endtask
  task automatic t_adapt();
    wr_reg(A_BOOST, 16'h0600);
    wr_reg(A_DROP, 16'hF800);
    wr_reg(A_RISE, 16'h0400);
    closed <= 1'b0;
    settle();
    chk({imp_640, 15'h0} ^ target, 16'hB000, "on hook");
    closed <= 1'b1;
    settle();
    chk({imp_640, 15'h0} ^ target, 16'h3600, "off hook");
    rd_reg(A_STATUS, d);
    chk(d & 16'h000C, 16'h000C, "in limit");
    closed <= 1'b0;
    settle();
    chk({imp_640, 15'h0} ^ target, 16'hB000, "back on");
    wr_reg(A_BOOST, 16'h0000);
    wr_reg(A_CURRENT_LIMIT, 16'h2000);
    closed <= 1'b1;
    settle();
    chk({imp_640, 15'h0} ^ target, 16'h3000, "no boost");
    rd_reg(A_STATUS, d);
    chk(d & 16'h000C, 16'h0004, "below limit");
    closed <= 1'b0;
    wr_reg(A_CTRL, 16'h0011);
    settle();
    chk({15'h0, imp_640}, 16'h0000, "discrete");
  endtask
  task automatic t_ground(input logic [2:0] code, input logic [15:0] lf_exp);
    wr_reg(A_CTRL, {13'h0, code});
    #1 chk({14'h0, tip_hiz, ring_hiz}, code == LF_TIP_LEAD_OPEN_STATE ? 16'h2 : 16'h1, "lead");
    settle();
    rd_reg(A_LOOP_VOLTAGE_SENSE, d);
    chk(d, code == LF_TIP_LEAD_OPEN_STATE ? 16'h0800 : 16'h0000, "gs loop_voltage_sense");
    gnd_key <= 1'b1;
    wait_active();
    rd_reg(A_STATUS, d);
    chk(d & 16'h0001, 16'h0001, "gk flag");
    rd_reg(A_CTRL, d);
    chk(d & 16'h0007, lf_exp, "gk state");
    chk({15'h0, reverse}, {15'h0, lf_exp == 16'h5}, "reverse");
    gnd_key <= 1'b0;
    wr_reg(A_STATUS, 16'h0001);
    rd_reg(A_STATUS, d);
    chk(d & 16'h0001, 16'h0000, "gk clear");
    repeat (800) @(posedge clk);
  endtask
  task automatic t_power();
    pwr <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({14'h0, tip_hiz, ring_hiz}, 16'h0003, "pwr leads");
    rd_reg(A_CTRL, d);
    chk(d & 16'h0007, 16'h0000, "pwr open");
    rd_reg(A_STATUS, d);
    chk(d & 16'h0002, 16'h0002, "pwr flag");
    pwr <= 1'b0;
  endtask
  task automatic t_rearm();
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk({11'h0, tip_hiz, ring_hiz, imp_640, reverse, cal_run}, 16'h001C, "rst again");
    rd_reg(A_STATUS, d);
    chk(d, 16'h0000, "rst status");
    t_cal();
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    err_count = 0;
    n_compared = 0;
    arst_n = 1'b0;
    {wr, rd, closed, gnd_key, pwr} = '0;
    addr = '0;
    wdata = '0;
    bat_v = 8'h40;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_cal();
    wr_reg(A_GKLO, 16'h0800);
    wr_reg(A_GKHI, 16'h1000);
    wr_reg(A_GKLPF, 16'h0080);
    wr_reg(A_GKDB, 16'h0002);
    t_track();
    t_sense();
    t_adapt();
    t_ground(LF_TIP_LEAD_OPEN_STATE, 16'h0001);
    t_ground(LF_RING_OPEN, 16'h0005);
    t_power();
    t_rearm();
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // test_adaptive_linefeed_monitor
